// >>> core/acc_alu.sv
// Accumulator arithmetic, logic and rotate unit.
// Assumes the caller decides when the result is stored.
`timescale 1ns/1ps
module acc_alu (
  input  flow_pkg::op_t op,
  input  wire logic [7:0] acc,
  input  wire logic [7:0] operand,
  input  wire logic       carry,
  input  wire logic       half,
  output logic [7:0]      acc_d,
  output logic            carry_d,
  output logic            half_d
);

  logic [8:0] sum;
  logic [4:0] nib;
  logic [7:0] rhs;
  logic [7:0] adj;

  always_comb begin
    rhs = (op == flow_pkg::SUB_WITH_CARRY) ? ~operand : operand;
    sum = {1'b0, acc} + {1'b0, rhs} + {8'h00, carry & (op != flow_pkg::ADD)};
    nib = {1'b0, acc[3:0]} + {1'b0, rhs[3:0]} + {4'h0, carry & (op != flow_pkg::ADD)};
    adj = acc;
    acc_d = acc;
    carry_d = carry;
    half_d = half;
    case (op)
      flow_pkg::ADD, flow_pkg::ADD_CARRY, flow_pkg::SUB_WITH_CARRY: begin
        acc_d = sum[7:0];
        if (op != flow_pkg::ADD) begin
          carry_d = sum[8];
          half_d = nib[4];
        end
      end
      flow_pkg::INCREMENT:        acc_d = acc + 8'h01;
      flow_pkg::SUBTRACT_ONE_ACC: acc_d = acc - 8'h01;
      flow_pkg::BCD_ADJUST: begin
        if (half || acc[3:0] > flow_pkg::DIGIT_MAX[3:0]) adj = adj + flow_pkg::LOW_ADJUST;
        if (carry || acc > 8'h99) begin
          adj = adj + flow_pkg::HIGH_ADJUST;
          carry_d = 1'b1;
        end
        acc_d = adj;
      end
      flow_pkg::ZERO_ACCUMULATOR: acc_d = 8'h00;
      flow_pkg::CARRY_SET: begin
        carry_d = 1'b1;
        half_d = 1'b1;
      end
      flow_pkg::CARRY_CLEAR: begin
        carry_d = 1'b0;
        half_d = 1'b0;
      end
      flow_pkg::AND_OP: acc_d = acc & operand;
      flow_pkg::OR_OP:  acc_d = acc | operand;
      flow_pkg::XOR_OP: acc_d = acc ^ operand;
      flow_pkg::ROTATE_RIGHT_CARRY: begin
        acc_d = {carry, acc[7:1]};
        carry_d = acc[0];
      end
      flow_pkg::ROTATE_LEFT_CARRY: begin
        acc_d = {acc[6:0], carry};
        carry_d = acc[7];
        half_d = acc[0];
      end
      flow_pkg::NIBBLE_SWAP: acc_d = {acc[3:0], acc[7:4]};
      flow_pkg::LOAD_ACC, flow_pkg::EXCHANGE_ACC: acc_d = operand;
      default: acc_d = acc;
    endcase
  end

endmodule : acc_alu

// >>> core/flow_pkg.sv
// Shared types and constants of the program flow sequencer.
// Assumes a single core clock and an asynchronous active-low reset.
package flow_pkg;

  // ------------------------------------------------------------
  // Widths, reset values and fixed addresses
  // ------------------------------------------------------------
  localparam int          PC_W         = 15;
  localparam int          SP_W         = 3;
  localparam int          STACK_DEPTH  = 8;
  localparam logic [14:0] PC_RESET     = 15'h0000;
  localparam logic [7:0]  ACC_RESET    = 8'h00;
  localparam logic [2:0]  SP_RESET     = 3'h0;
  localparam logic [14:0] TRAP_VECTOR  = 15'h00FF;
  localparam logic [14:0] VECTOR_BASE  = 15'h7FE0;
  localparam logic [14:0] SHORT_BIAS   = 15'h001F;
  localparam logic [7:0]  DIGIT_MAX    = 8'h09;
  localparam logic [7:0]  LOW_ADJUST   = 8'h06;
  localparam logic [7:0]  HIGH_ADJUST  = 8'h60;

  // ------------------------------------------------------------
  // Operations and sequencer states
  // ------------------------------------------------------------
  typedef enum logic [5:0] {
    NOP, ADD, ADD_CARRY, SUB_WITH_CARRY, INCREMENT, SUBTRACT_ONE_ACC,
    BCD_ADJUST, ZERO_ACCUMULATOR, CARRY_SET, CARRY_CLEAR,
    AND_OP, OR_OP, XOR_OP, ROTATE_RIGHT_CARRY, ROTATE_LEFT_CARRY,
    NIBBLE_SWAP, LOAD_ACC, EXCHANGE_ACC, TABLE_LOAD,
    JUMP_SHORT, JUMP_PAGE, JUMP_FAR, TABLE_JUMP,
    CALL_NEAR, CALL_FAR, CALL_BOOT_ROM, SUBROUTINE_EXIT,
    SUBROUTINE_EXIT_SKIP, INTERRUPT_EXIT, SOFTWARE_TRAP, VECTOR_SELECT,
    BIT_SET_OP, BIT_CLEAR_OP, PENDING_FLAG_CLEAR,
    SKIP_UNLESS_EQUAL, SKIP_UNLESS_UNEQUAL, SKIP_UNLESS_GREATER,
    SKIP_UNLESS_CARRY, SKIP_IF_CARRY, SKIP_UNLESS_BIT,
    SKIP_UNLESS_POINTER_LOW_DIFFERS, MASK_SKIP_ZERO, COUNT_DOWN_SKIP_ZERO
  } op_t;

  typedef enum logic [1:0] {S_IDLE, S_WAIT, S_TAKE} state_t;

  // ------------------------------------------------------------
  // Carriers
  // ------------------------------------------------------------
  typedef struct packed {
    op_t         op;
    logic        with_imm;
    logic [7:0]  operand;
    logic [7:0]  imm;
    logic [14:0] target;
    logic [1:0]  len;
  } issue_t;

  typedef struct packed {
    logic        rd;
    logic [14:0] addr;
  } pm_req_t;

  typedef struct packed {
    logic       we;
    logic [7:0] data;
  } wb_t;

endpackage : flow_pkg

// >>> core/program_flow_sequencer.sv
// Program counter, accumulator, flags, return stack, skip.
// Reads program memory for table and vector operations.
// Assumes a decoder that resolves operands in front,
// and memory data valid one cycle after a read strobe.
//
// What this block does
// - Table load: accumulator replaces low PC byte
// - Table byte to accumulator, low PC restored
// - Fifteen-bit program counter, no sixteenth bit
// - Short jump carries six displacement bits
// - Short jump reaches -31 to +32
// - Page jump keeps top three PC bits
// - Far jump loads all fifteen PC bits
// - Table jump loads fetched byte into low PC
// - Vector select loads two-byte vector into PC
// - Condition true runs next, false skips it
// - Skipped instruction acts as no-operation
// - Nine conditional tests are supported
// - Calls push PC before loading target
// - Returns pop top of stack into PC
// - Add, subtract, increment, decrement, adjust, carry ops
// - AND, OR, XOR into accumulator
// - Rotates through carry and nibble swap
// - Bit set/clear also clear pending flag
// - No-operation changes nothing but PC
// - Pointer test compares B low nibble
// - Count down register, skip on zero
// - Right rotate: carry in top, bit0 out
`timescale 1ns/1ps
module program_flow_sequencer (
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  input  wire logic         issue_valid,
  input  flow_pkg::issue_t  issue,
  input  wire logic [7:0]   b_ptr,
  input  wire logic [3:0]   vector_index,
  input  wire logic [7:0]   pm_data,
  output logic              issue_ready_q,
  output logic              retire_q,
  output logic [14:0]       pc_q,
  output logic [7:0]        acc_q,
  output logic              carry_q,
  output logic              half_carry_q,
  output logic              skip_q,
  output flow_pkg::pm_req_t pm_q,
  output flow_pkg::wb_t     wb_q,
  output logic              pending_clr_q
);

  // ------------------------------------------------------------
  // State and next-state signals
  // ------------------------------------------------------------
  flow_pkg::state_t  state_q;
  flow_pkg::state_t  state_d;
  flow_pkg::issue_t  cur_q;
  flow_pkg::pm_req_t pm_d;
  flow_pkg::wb_t     wb_d;
  logic [14:0]       pc_d;
  logic [14:0]       seq_pc;
  logic [14:0]       page_pc;
  logic [14:0]       short_pc;
  logic [14:0]       top_pc;
  logic [7:0]        lo_save_q;
  logic [7:0]        lo_save_d;
  logic [6:0]        vec_hi_q;
  logic [6:0]        vec_hi_d;
  logic              second_q;
  logic              second_d;
  logic              skip_d;
  logic              pend_d;
  logic              push;
  logic              pop;
  logic              alu_we;
  logic              tbl_we;
  logic              retire_d;
  logic              cond;
  logic [7:0]        cmp_l;
  logic [7:0]        cmp_r;
  logic [7:0]        bit_src;
  logic [7:0]        bit_mask;
  logic [7:0]        count_dn;
  logic [7:0]        alu_acc;
  logic              alu_c;
  logic              alu_hc;
  logic [14:0]       stack_mem [flow_pkg::STACK_DEPTH];
  logic [2:0]        sp_q;

  // ------------------------------------------------------------
  // Target arithmetic
  // ------------------------------------------------------------
  // No sixteenth counter bit is kept
  assign seq_pc   = pc_q + {13'h0000, issue.len};
  assign page_pc  = {pc_q[14:12], issue.target[11:0]};
  // Code 0..63 maps onto -31..+32; wraps modulo the 15-bit space
  assign short_pc = pc_q + {9'h000, issue.target[5:0]} - flow_pkg::SHORT_BIAS;
  assign top_pc   = stack_mem[sp_q - 3'h1];
  assign bit_mask = 8'h01 << issue.target[2:0];
  assign count_dn = issue.operand - 8'h01;

  acc_alu u_alu (
    .op      (issue.op),
    .acc     (acc_q),
    .operand (issue.operand),
    .carry   (carry_q),
    .half    (half_carry_q),
    .acc_d   (alu_acc),
    .carry_d (alu_c),
    .half_d  (alu_hc)
  );

  // ------------------------------------------------------------
  // Condition evaluation
  // ------------------------------------------------------------
  always_comb begin
    cmp_l = issue.with_imm ? issue.operand : acc_q;
    cmp_r = issue.with_imm ? issue.imm : issue.operand;
    bit_src = issue.with_imm ? acc_q : issue.operand;
    case (issue.op)
      flow_pkg::SKIP_UNLESS_EQUAL:               cond = (cmp_l == cmp_r);
      flow_pkg::SKIP_UNLESS_UNEQUAL:             cond = (cmp_l != cmp_r);
      flow_pkg::SKIP_UNLESS_GREATER:             cond = (cmp_l > cmp_r);
      flow_pkg::SKIP_UNLESS_CARRY:               cond = carry_q;
      flow_pkg::SKIP_IF_CARRY:                   cond = !carry_q;
      flow_pkg::SKIP_UNLESS_BIT:                 cond = |(bit_src & bit_mask);
      flow_pkg::SKIP_UNLESS_POINTER_LOW_DIFFERS: cond = (b_ptr[3:0] != issue.imm[3:0]);
      flow_pkg::MASK_SKIP_ZERO:                  cond = |(acc_q & issue.imm);
      flow_pkg::COUNT_DOWN_SKIP_ZERO:            cond = (count_dn != 8'h00);
      default:                                   cond = 1'b1;
    endcase
  end

  // ------------------------------------------------------------
  // Sequencing decisions
  // ------------------------------------------------------------
  always_comb begin
    state_d   = state_q;
    pc_d      = pc_q;
    pm_d      = '{rd: 1'b0, addr: pm_q.addr};
    wb_d      = '{we: 1'b0, data: wb_q.data};
    lo_save_d = lo_save_q;
    vec_hi_d  = vec_hi_q;
    second_d  = second_q;
    skip_d    = skip_q;
    pend_d    = 1'b0;
    push      = 1'b0;
    pop       = 1'b0;
    alu_we    = 1'b0;
    tbl_we    = 1'b0;
    retire_d  = 1'b0;
    case (state_q)
      flow_pkg::S_IDLE: begin
        if (issue_valid) begin
          pc_d = seq_pc;
          retire_d = 1'b1;
          skip_d = 1'b0;
          // A skipped slot only moves the counter
          if (!skip_q) begin
            case (issue.op)
              flow_pkg::NOP: pc_d = seq_pc;
              flow_pkg::JUMP_SHORT: pc_d = short_pc;
              flow_pkg::JUMP_PAGE:  pc_d = page_pc;
              flow_pkg::JUMP_FAR:   pc_d = issue.target;
              flow_pkg::CALL_NEAR: begin
                push = 1'b1;
                pc_d = page_pc;
              end
              flow_pkg::CALL_FAR, flow_pkg::CALL_BOOT_ROM: begin
                push = 1'b1;
                pc_d = issue.target;
              end
              flow_pkg::SOFTWARE_TRAP: begin
                push = 1'b1;
                pc_d = flow_pkg::TRAP_VECTOR;
              end
              flow_pkg::SUBROUTINE_EXIT, flow_pkg::INTERRUPT_EXIT: begin
                pop = 1'b1;
                pc_d = top_pc;
              end
              flow_pkg::SUBROUTINE_EXIT_SKIP: begin
                pop = 1'b1;
                pc_d = top_pc;
                skip_d = 1'b1;
              end
              flow_pkg::TABLE_LOAD, flow_pkg::TABLE_JUMP: begin
                // Low byte is the pointer while the read is out
                lo_save_d = pc_q[7:0];
                pc_d = {pc_q[14:8], acc_q};
                pm_d = '{rd: 1'b1, addr: {pc_q[14:8], acc_q}};
                state_d = flow_pkg::S_WAIT;
                retire_d = 1'b0;
              end
              flow_pkg::VECTOR_SELECT: begin
                pc_d = pc_q;
                second_d = 1'b0;
                pm_d = '{rd: 1'b1, addr: flow_pkg::VECTOR_BASE | {10'h000, vector_index, 1'b0}};
                state_d = flow_pkg::S_WAIT;
                retire_d = 1'b0;
              end
              flow_pkg::BIT_SET_OP: begin
                wb_d = '{we: 1'b1, data: issue.operand | bit_mask};
                pend_d = 1'b1;
              end
              flow_pkg::BIT_CLEAR_OP: begin
                wb_d = '{we: 1'b1, data: issue.operand & ~bit_mask};
                pend_d = 1'b1;
              end
              flow_pkg::PENDING_FLAG_CLEAR: pend_d = 1'b1;
              flow_pkg::COUNT_DOWN_SKIP_ZERO: begin
                wb_d = '{we: 1'b1, data: count_dn};
                skip_d = !cond;
              end
              flow_pkg::EXCHANGE_ACC: begin
                wb_d = '{we: 1'b1, data: acc_q};
                alu_we = 1'b1;
              end
              flow_pkg::SKIP_UNLESS_EQUAL, flow_pkg::SKIP_UNLESS_UNEQUAL,
              flow_pkg::SKIP_UNLESS_GREATER, flow_pkg::SKIP_UNLESS_CARRY,
              flow_pkg::SKIP_IF_CARRY, flow_pkg::SKIP_UNLESS_BIT,
              flow_pkg::SKIP_UNLESS_POINTER_LOW_DIFFERS,
              flow_pkg::MASK_SKIP_ZERO: skip_d = !cond;
              default: alu_we = 1'b1;
            endcase
          end
        end
      end
      flow_pkg::S_WAIT: state_d = flow_pkg::S_TAKE;
      flow_pkg::S_TAKE: begin
        state_d = flow_pkg::S_IDLE;
        retire_d = 1'b1;
        case (cur_q.op)
          flow_pkg::TABLE_LOAD: begin
            tbl_we = 1'b1;
            pc_d = {pc_q[14:8], lo_save_q} + {13'h0000, cur_q.len};
          end
          flow_pkg::TABLE_JUMP: pc_d = {pc_q[14:8], pm_data};
          flow_pkg::VECTOR_SELECT: begin
            if (!second_q) begin
              vec_hi_d = pm_data[6:0];
              second_d = 1'b1;
              pm_d = '{rd: 1'b1, addr: pm_q.addr + 15'h0001};
              state_d = flow_pkg::S_WAIT;
              retire_d = 1'b0;
            end else begin
              pc_d = {vec_hi_q, pm_data};
            end
          end
          default: pc_d = pc_q;
        endcase
      end
      default: state_d = flow_pkg::S_IDLE;
    endcase
  end

  // ------------------------------------------------------------
  // Sequencer state and program memory port
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q       <= flow_pkg::S_IDLE;
      issue_ready_q <= 1'b1;
      retire_q      <= 1'b0;
      pm_q          <= '0;
      cur_q         <= '0;
      lo_save_q     <= 8'h00;
      vec_hi_q      <= 7'h00;
      second_q      <= 1'b0;
    end else begin
      state_q       <= state_d;
      issue_ready_q <= (state_d == flow_pkg::S_IDLE);
      retire_q      <= retire_d;
      pm_q          <= pm_d;
      lo_save_q     <= lo_save_d;
      vec_hi_q      <= vec_hi_d;
      second_q      <= second_d;
      if (state_q == flow_pkg::S_IDLE && issue_valid) begin
        cur_q <= issue;
      end
    end
  end

  // ------------------------------------------------------------
  // Program counter and skip flag
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pc_q   <= flow_pkg::PC_RESET;
      skip_q <= 1'b0;
    end else begin
      pc_q   <= pc_d;
      skip_q <= skip_d;
    end
  end

  // ------------------------------------------------------------
  // Accumulator and carry flags
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_q        <= flow_pkg::ACC_RESET;
      carry_q      <= 1'b0;
      half_carry_q <= 1'b0;
    end else if (tbl_we) begin
      acc_q <= pm_data;
    end else if (alu_we) begin
      acc_q        <= alu_acc;
      carry_q      <= alu_c;
      half_carry_q <= alu_hc;
    end
  end

  // ------------------------------------------------------------
  // Data write-back and pending-flag clear
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_q          <= '0;
      pending_clr_q <= 1'b0;
    end else begin
      wb_q          <= wb_d;
      pending_clr_q <= pend_d;
    end
  end

  // ------------------------------------------------------------
  // Return stack
  // ------------------------------------------------------------
  // Wraps silently; software owns nesting depth
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sp_q <= flow_pkg::SP_RESET;
    end else if (push) begin
      sp_q <= sp_q + 3'h1;
    end else if (pop) begin
      sp_q <= sp_q - 3'h1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (push) begin
      stack_mem[sp_q] <= seq_pc;
    end
  end

endmodule : program_flow_sequencer

// >>> sim/prog_mem_model.sv
// Program memory model for table and vector reads.
// Assumes a read strobe; data is wanted one cycle later.
`timescale 1ns/1ps
module prog_mem_model (
  input  wire logic        core_clk,
  input  flow_pkg::pm_req_t pm_q,
  output logic [7:0]       pm_data
);
  // ------------------------------------------------------------
  // Contents and read timing
  // ------------------------------------------------------------
  function automatic logic [7:0] rom(input logic [14:0] a);
    return a[7:0] ^ {1'b0, a[14:8]} ^ 8'h3C;
  endfunction : rom

  initial pm_data = 8'hA5;

  // Data stands one cycle, then flips to expose late sampling
  always @(posedge core_clk) begin
    if (pm_q.rd) begin
      pm_data <= rom(pm_q.addr);
    end else begin
      pm_data <= ~pm_data;
    end
  end
endmodule : prog_mem_model

// >>> sim/program_flow_sequencer_props.sv
// Port checks of the program flow sequencer.
// Assumes one clock and the memory hand-over timing.
`timescale 1ns/1ps
module program_flow_sequencer_props (
  input wire logic          core_clk,
  input wire logic          rst_n,
  input wire logic          issue_valid,
  input flow_pkg::issue_t   issue,
  input wire logic [3:0]    vector_index,
  input wire logic [7:0]    pm_data,
  input wire logic          issue_ready_q,
  input wire logic          retire_q,
  input wire logic [14:0]   pc_q,
  input wire logic [7:0]    acc_q,
  input wire logic          skip_q,
  input flow_pkg::pm_req_t  pm_q,
  input flow_pkg::wb_t      wb_q,
  input wire logic          pending_clr_q
);
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic take;
  assign take = issue_valid && issue_ready_q && !skip_q;

  a_table_pointer:
    assert property (take && issue.op == flow_pkg::TABLE_LOAD |=> pm_q.rd
      && pm_q.addr == {$past(pc_q[14:8]), $past(acc_q)}) else $error("table pointer wrong");
  a_table_restore:
    assert property (take && issue.op == flow_pkg::TABLE_LOAD |=> !retire_q ##1 !retire_q
      ##1 (retire_q && acc_q == $past(pm_data) && pc_q == $past(pc_q, 3)
      + 15'($past(issue.len, 3)))) else $error("table load result wrong");
  a_table_jump:
    assert property (take && issue.op == flow_pkg::TABLE_JUMP |-> ##3 retire_q
      && pc_q == {$past(pc_q[14:8], 3), $past(pm_data)} && acc_q == $past(acc_q, 3))
    else $error("table jump wrong");
  a_vector_fetch:
    assert property (take && issue.op == flow_pkg::VECTOR_SELECT |=> pm_q.rd
      && pm_q.addr == (flow_pkg::VECTOR_BASE | 15'({$past(vector_index), 1'b0}))
      ##2 pm_q.rd ##2 (retire_q && pc_q == {$past(pm_data[6:0], 3), $past(pm_data)}))
    else $error("vector load wrong");
  a_short_reach:
    assert property (take && issue.op == flow_pkg::JUMP_SHORT |=> pc_q == $past(pc_q)
      + 15'($past(issue.target[5:0])) - 15'h001F) else $error("short jump target wrong");
  a_page_jump:
    assert property (take && issue.op == flow_pkg::JUMP_PAGE |=>
      pc_q == {$past(pc_q[14:12]), $past(issue.target[11:0])}) else $error("page jump wrong");
  a_far_jump:
    assert property (take && issue.op == flow_pkg::JUMP_FAR |=> pc_q == $past(issue.target))
    else $error("far jump wrong");
  a_skip_noop:
    assert property (issue_valid && issue_ready_q && skip_q |=> retire_q && !skip_q
      && !wb_q.we && acc_q == $past(acc_q) && pc_q == $past(pc_q) + 15'($past(issue.len)))
    else $error("skipped instruction had an effect");
  a_bit_pending:
    assert property (take && (issue.op == flow_pkg::BIT_SET_OP
      || issue.op == flow_pkg::BIT_CLEAR_OP) |=> pending_clr_q && wb_q.we)
    else $error("bit op did not clear pending");
endmodule : program_flow_sequencer_props

bind program_flow_sequencer program_flow_sequencer_props i_props (.core_clk, .rst_n,
  .issue_valid, .issue, .vector_index, .pm_data, .issue_ready_q, .retire_q, .pc_q, .acc_q,
  .skip_q, .pm_q, .wb_q, .pending_clr_q);

// >>> sim/program_flow_sequencer_tb.sv
// Self-checking bench with a reference model of the sequencer.
// Assumes the program memory model beside the design.
`timescale 1ns/1ps
module program_flow_sequencer_tb;
  logic              core_clk, rst_n, issue_valid;
  flow_pkg::issue_t  issue;
  logic [7:0]        b_ptr, pm_data, acc_q, m_acc;
  logic [3:0]        vector_index;
  logic              issue_ready_q, retire_q, carry_q, half_carry_q, skip_q, pending_clr_q;
  logic [14:0]       pc_q, m_pc, stk[$];
  flow_pkg::pm_req_t pm_q;
  flow_pkg::wb_t     wb_q;
  logic              m_c, m_h, m_skip;
  logic [5:0]        c6;
  int                n_errors = 0, samples_checked = 0;
  flow_pkg::op_t     alu[10] = '{flow_pkg::OR_OP, flow_pkg::AND_OP, flow_pkg::XOR_OP,
    flow_pkg::ADD, flow_pkg::ROTATE_RIGHT_CARRY, flow_pkg::NIBBLE_SWAP, flow_pkg::CARRY_SET,
    flow_pkg::ROTATE_RIGHT_CARRY, flow_pkg::NOP, flow_pkg::CARRY_CLEAR};
  flow_pkg::op_t     cnd[9] = '{flow_pkg::SKIP_UNLESS_EQUAL, flow_pkg::SKIP_UNLESS_UNEQUAL,
    flow_pkg::SKIP_UNLESS_GREATER, flow_pkg::SKIP_UNLESS_CARRY, flow_pkg::SKIP_IF_CARRY,
    flow_pkg::SKIP_UNLESS_BIT, flow_pkg::SKIP_UNLESS_POINTER_LOW_DIFFERS,
    flow_pkg::MASK_SKIP_ZERO, flow_pkg::COUNT_DOWN_SKIP_ZERO};

  program_flow_sequencer i_program_flow_sequencer (.core_clk(core_clk), .rst_n(rst_n),
    .issue_valid(issue_valid), .issue(issue), .b_ptr(b_ptr), .vector_index(vector_index),
    .pm_data(pm_data), .issue_ready_q(issue_ready_q), .retire_q(retire_q), .pc_q(pc_q),
    .acc_q(acc_q), .carry_q(carry_q), .half_carry_q(half_carry_q), .skip_q(skip_q),
    .pm_q(pm_q), .wb_q(wb_q), .pending_clr_q(pending_clr_q));
  prog_mem_model i_prog_mem_model (.core_clk(core_clk), .pm_q(pm_q), .pm_data(pm_data));

  always #50 core_clk = ~core_clk;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [7:0] rom(input logic [14:0] a);
    return a[7:0] ^ {1'b0, a[14:8]} ^ 8'h3C;
  endfunction : rom

  task automatic check(input string what, input logic [14:0] exp, input logic [14:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic complete_run();
    $display("Checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : complete_run

  // Offer one instruction, wait for retire, compare
  task automatic run(input flow_pkg::op_t op, input logic [7:0] o = 8'h00,
                     input logic [7:0] im = 8'h00, input logic [14:0] t = 15'h0000);
    int          n;
    logic [14:0] nxt, va;
    logic [7:0]  hi;
    logic        skipped;
    n = 0;
    @(negedge core_clk);
    issue_valid = 1'b1;
    issue = '{op: op, with_imm: 1'b0, operand: o, imm: im, target: t,
              len: 2'($urandom_range(1, 3))};
    @(negedge core_clk);
    issue_valid = 1'b0;
    while (retire_q !== 1'b1 && n < 10) begin
      @(negedge core_clk);
      n++;
    end
    skipped = m_skip;
    nxt = m_pc + 15'(issue.len);
    m_skip = 1'b0;
    if (!skipped) begin
      case (op)
        flow_pkg::ZERO_ACCUMULATOR: m_acc = 8'h00;
        flow_pkg::OR_OP: m_acc = m_acc | o;
        flow_pkg::AND_OP: m_acc = m_acc & o;
        flow_pkg::XOR_OP: m_acc = m_acc ^ o;
        flow_pkg::ADD: m_acc = m_acc + o;
        flow_pkg::ROTATE_RIGHT_CARRY: {m_acc, m_c} = {m_c, m_acc};
        flow_pkg::NIBBLE_SWAP: m_acc = {m_acc[3:0], m_acc[7:4]};
        flow_pkg::CARRY_SET: {m_c, m_h} = 2'b11;
        flow_pkg::CARRY_CLEAR: {m_c, m_h} = 2'b00;
        flow_pkg::JUMP_SHORT: nxt = m_pc + 15'(t[5:0]) - 15'h001F;
        flow_pkg::JUMP_PAGE: nxt = {m_pc[14:12], t[11:0]};
        flow_pkg::JUMP_FAR: nxt = t;
        flow_pkg::CALL_NEAR: begin
          stk.push_back(nxt);
          nxt = {m_pc[14:12], t[11:0]};
        end
        flow_pkg::CALL_FAR: begin
          stk.push_back(nxt);
          nxt = t;
        end
        flow_pkg::SUBROUTINE_EXIT: nxt = stk.pop_back();
        flow_pkg::SUBROUTINE_EXIT_SKIP: begin
          nxt = stk.pop_back();
          m_skip = 1'b1;
        end
        flow_pkg::TABLE_LOAD: m_acc = rom({m_pc[14:8], m_acc});
        flow_pkg::TABLE_JUMP: nxt = {m_pc[14:8], rom({m_pc[14:8], m_acc})};
        flow_pkg::VECTOR_SELECT: begin
          va = flow_pkg::VECTOR_BASE | 15'({vector_index, 1'b0});
          hi = rom(va);
          nxt = {hi[6:0], rom(va + 15'h0001)};
        end
        flow_pkg::SKIP_UNLESS_EQUAL: m_skip = (m_acc != o);
        flow_pkg::SKIP_UNLESS_UNEQUAL: m_skip = (m_acc == o);
        flow_pkg::SKIP_UNLESS_GREATER: m_skip = (m_acc <= o);
        flow_pkg::SKIP_UNLESS_CARRY: m_skip = !m_c;
        flow_pkg::SKIP_IF_CARRY: m_skip = m_c;
        flow_pkg::SKIP_UNLESS_BIT: m_skip = !o[t[2:0]];
        flow_pkg::SKIP_UNLESS_POINTER_LOW_DIFFERS: m_skip = (b_ptr[3:0] == im[3:0]);
        flow_pkg::MASK_SKIP_ZERO: m_skip = ((m_acc & im) == 8'h00);
        flow_pkg::COUNT_DOWN_SKIP_ZERO: m_skip = (o == 8'h01);
        default: ;
      endcase
    end
    m_pc = nxt;
    check("pc", m_pc, pc_q);
    check("acc", 15'(m_acc), 15'(acc_q));
    check("flags", 15'({m_c, m_h}), 15'({carry_q, half_carry_q}));
    check("skip", 15'(m_skip), 15'(skip_q));
    if (op == flow_pkg::BIT_SET_OP && !skipped) begin
      check("wb_data", 15'(o | (8'h01 << t[2:0])), 15'(wb_q.data));
    end
  endtask : run

  task automatic setacc(input logic [7:0] v);
    run(flow_pkg::ZERO_ACCUMULATOR);
    run(flow_pkg::OR_OP, v);
  endtask : setacc

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    rst_n = 1'b0;
    issue_valid = 1'b0;
    issue = '0;
    b_ptr = 8'h00;
    vector_index = 4'h0;
    m_pc = 15'h0000;
    m_acc = 8'h00;
    {m_c, m_h, m_skip} = 3'h0;
    void'($urandom(42));
    repeat (2) @(negedge core_clk);
    rst_n = 1'b1;
    check("ready", 15'h0001, 15'(issue_ready_q));
    check("pc", 15'h0000, pc_q);
    foreach (alu[i]) run(alu[i], 8'($urandom));
    run(flow_pkg::JUMP_FAR);
    // From address zero a backward short jump wraps
    run(flow_pkg::JUMP_SHORT);
    repeat (4) begin
      c6 = 6'($urandom);
      if (c6 == 6'h20) c6 = 6'h21;
      run(flow_pkg::JUMP_SHORT, 8'h00, 8'h00, 15'(c6));
      run(flow_pkg::JUMP_PAGE, 8'h00, 8'h00, 15'($urandom));
      run(flow_pkg::JUMP_FAR, 8'h00, 8'h00, 15'($urandom));
      setacc(8'($urandom));
      run(flow_pkg::TABLE_LOAD);
      run(flow_pkg::TABLE_JUMP);
      vector_index = 4'($urandom);
      run(flow_pkg::VECTOR_SELECT);
    end
    run(flow_pkg::CALL_NEAR, 8'h00, 8'h00, 15'($urandom));
    run(flow_pkg::CALL_FAR, 8'h00, 8'h00, 15'($urandom));
    run(flow_pkg::SUBROUTINE_EXIT);
    run(flow_pkg::SUBROUTINE_EXIT_SKIP);
    run(flow_pkg::TABLE_LOAD);
    // Small values so both outcomes of every test occur
    repeat (4) foreach (cnd[i]) begin
      setacc(8'($urandom_range(0, 3)));
      run($urandom_range(0, 1) ? flow_pkg::CARRY_SET : flow_pkg::CARRY_CLEAR);
      b_ptr = {4'($urandom), 4'($urandom_range(0, 3))};
      run(cnd[i], 8'($urandom_range(0, 3)), 8'($urandom_range(0, 3)),
          15'($urandom_range(0, 7)));
      run(flow_pkg::ADD, 8'($urandom));
    end
    run(flow_pkg::BIT_SET_OP, 8'($urandom), 8'h00, 15'($urandom_range(0, 7)));
    complete_run();
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    n_errors++;
    complete_run();
  end
endmodule : program_flow_sequencer_tb
